// *** logic/charger_status_pkg.sv ***
// Constants and types of the charger status and event flag registers
package charger_status_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    localparam logic [ADDR_W-1:0] STATUS_TWO_ADDR   = 8'h02;
    localparam logic [ADDR_W-1:0] STATUS_THREE_ADDR = 8'h03;
    localparam logic [ADDR_W-1:0] EVENT_FLAGS_ADDR  = 8'h04;

    localparam logic [DATA_W-1:0] EVENT_FLAGS_RESET = 8'h00;
    localparam logic [DATA_W-1:0] READ_DATA_RESET   = 8'h00;
    localparam logic [DATA_W-1:0] UNMAPPED_VALUE    = 8'h00;

    // Status two fields
    localparam int unsigned PHASE_MSB        = 7;
    localparam int unsigned PHASE_LSB        = 6;
    localparam int unsigned SEQ_PG_BIT       = 5;
    localparam int unsigned IN_PG_BIT        = 1;
    localparam int unsigned IN_OVP_BIT       = 0;
    // Status three fields
    localparam int unsigned PIN_MSB          = 7;
    localparam int unsigned PIN_LSB          = 4;
    localparam int unsigned DEPLETION_BIT    = 1;
    localparam int unsigned THERMAL_SHUT_BIT = 0;
    // Event flag fields
    localparam int unsigned FLAG_OPEN_BIT    = 7;
    localparam int unsigned FLAG_ZONE_BIT    = 6;
    localparam int unsigned FLAG_ILIM_BIT    = 2;
    localparam int unsigned FLAG_PPATH_BIT   = 1;
    localparam int unsigned FLAG_VIN_BIT     = 0;
    localparam logic [DATA_W-1:0] FLAG_DEFINED_MASK = 8'hc7;

    localparam logic [1:0] PHASE_IDLE = 2'h0;
    localparam logic [1:0] PHASE_CC   = 2'h1;
    localparam logic [1:0] PHASE_CV   = 2'h2;
    localparam logic [1:0] PHASE_DONE = 2'h3;

    localparam logic [2:0] ZONE_NORMAL = 3'h0;
    localparam logic [2:0] ZONE_COLD   = 3'h1;
    localparam logic [2:0] ZONE_HOT    = 3'h2;
    localparam logic [2:0] ZONE_COOL   = 3'h3;
    localparam logic [2:0] ZONE_WARM   = 3'h4;

    // Cycles after reset before edges are trusted (synchroniser fill)
    localparam logic [1:0] PRIME_CYCLES = 2'h3;

    typedef struct packed {
        logic [1:0] charge_phase;
        logic       sequence_power_good;
        logic       input_power_good;
        logic       input_overvoltage;
        logic [3:0] pin_level;
        logic       battery_depletion_fault;
        logic       thermal_shutdown;
        logic       thermistor_open;
        logic [2:0] thermistor_zone;
        logic       current_limit;
        logic       power_path_regulation;
        logic       input_voltage_regulation;
    } status_raw_type;

endpackage : charger_status_pkg

// *** logic/status_sync_if.sv ***
// Interface carrying raw and synchronised monitor levels
`timescale 1ns/100ps
interface status_sync_if;
    import charger_status_pkg::*;

    status_raw_type raw;
    status_raw_type sync;

    modport sync_side (input raw, output sync);
    modport user_side (output raw, input sync);
endinterface : status_sync_if

// *** logic/status_sync.sv ***
// Two-stage synchroniser for all monitored levels
`timescale 1ns/100ps
module status_sync
    import charger_status_pkg::*;
(
    input  wire logic      clk_sys,
    input  wire logic      reset,
    status_sync_if.sync_side bus
);

    typedef struct packed {
        status_raw_type meta;
        status_raw_type stable;
    } sync_state_type;

    sync_state_type state_q;
    sync_state_type state_d;

    always_comb
    begin
        state_d        = state_q;
        state_d.meta   = bus.raw;
        state_d.stable = state_q.meta;
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            state_q <= '0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign bus.sync = state_q.stable;

endmodule : status_sync

// *** logic/charger_status_flag_regs.sv ***
// Live charger status registers and clear-on-read event flags
`timescale 1ns/100ps
module charger_status_flag_regs
    import charger_status_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              reset,
    input  wire logic              rd_en,
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic      [DATA_W-1:0] rd_data,
    output logic                   rd_valid,
    input  wire logic [1:0]        charge_phase,
    input  wire logic              sequence_power_good,
    input  wire logic              input_power_good,
    input  wire logic              input_overvoltage,
    input  wire logic              pin1_level,
    input  wire logic              pin2_level,
    input  wire logic              pin3_level,
    input  wire logic              pin4_level,
    input  wire logic              battery_depletion_fault,
    input  wire logic              thermal_shutdown,
    input  wire logic              thermistor_open,
    input  wire logic [2:0]        thermistor_zone,
    input  wire logic              current_limit,
    input  wire logic              power_path_regulation,
    input  wire logic              input_voltage_regulation
);

    typedef struct packed {
        logic [DATA_W-1:0] rd_data;
        logic              rd_valid;
        logic [DATA_W-1:0] flags;
        status_raw_type    prev;
        logic [1:0]        prime;
    } regs_state_type;

    regs_state_type    state_q;
    regs_state_type    state_d;
    status_raw_type    live;
    logic [DATA_W-1:0] flag_set;
    logic [DATA_W-1:0] flag_clear;
    logic              primed;

    status_sync_if sync_bus ();

    // One driver for the whole word, in status_raw_type field order
    assign sync_bus.raw = {charge_phase,
                           sequence_power_good,
                           input_power_good,
                           input_overvoltage,
                           pin1_level,
                           pin2_level,
                           pin3_level,
                           pin4_level,
                           battery_depletion_fault,
                           thermal_shutdown,
                           thermistor_open,
                           thermistor_zone,
                           current_limit,
                           power_path_regulation,
                           input_voltage_regulation};

    status_sync u_status_sync (
        .clk_sys (clk_sys),
        .reset   (reset),
        .bus     (sync_bus.sync_side)
    );

    assign live = sync_bus.sync;

    // Register read mux; status registers are composed live
    function automatic logic [DATA_W-1:0] read_value(
        input logic [ADDR_W-1:0] addr,
        input status_raw_type    s,
        input logic [DATA_W-1:0] f
    );
        logic [DATA_W-1:0] v;
        v = UNMAPPED_VALUE;
        unique case (addr)
            STATUS_TWO_ADDR:
            begin
                v[PHASE_MSB:PHASE_LSB] = s.charge_phase;
                v[SEQ_PG_BIT]          = s.sequence_power_good;
                v[IN_PG_BIT]           = s.input_power_good;
                v[IN_OVP_BIT]          = s.input_overvoltage;
            end
            STATUS_THREE_ADDR:
            begin
                v[PIN_MSB:PIN_LSB]     = s.pin_level;
                v[DEPLETION_BIT]       = s.battery_depletion_fault;
                v[THERMAL_SHUT_BIT]    = s.thermal_shutdown;
            end
            EVENT_FLAGS_ADDR:
            begin
                v = f & FLAG_DEFINED_MASK;
            end
            default:
            begin
                v = UNMAPPED_VALUE;
            end
        endcase
        return v;
    endfunction : read_value

    always_comb
    begin
        state_d    = state_q;
        flag_set   = 8'h00;
        flag_clear = 8'h00;
        primed     = (state_q.prime == PRIME_CYCLES);
        if (!primed)
        begin
            state_d.prime = state_q.prime + 2'h1;
        end
        else
        begin
            flag_set[FLAG_OPEN_BIT]  = live.thermistor_open
                                       & ~state_q.prev.thermistor_open;
            flag_set[FLAG_ZONE_BIT]  = (live.thermistor_zone
                                        != state_q.prev.thermistor_zone);
            flag_set[FLAG_ILIM_BIT]  = live.current_limit
                                       & ~state_q.prev.current_limit;
            flag_set[FLAG_PPATH_BIT] = live.power_path_regulation
                                       & ~state_q.prev.power_path_regulation;
            flag_set[FLAG_VIN_BIT]   = live.input_voltage_regulation
                                       & ~state_q.prev.input_voltage_regulation;
        end
        if (rd_en && (rd_addr == EVENT_FLAGS_ADDR))
        begin
            flag_clear = FLAG_DEFINED_MASK;
        end
        // Set after clear so a coincident event survives the read
        state_d.flags    = ((state_q.flags & ~flag_clear) | flag_set)
                           & FLAG_DEFINED_MASK;
        state_d.prev     = live;
        state_d.rd_valid = rd_en;
        if (rd_en)
        begin
            state_d.rd_data = read_value(rd_addr, live, state_q.flags);
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            state_q          <= '0;
            state_q.rd_data  <= READ_DATA_RESET;
            state_q.flags    <= EVENT_FLAGS_RESET;
            state_q.prime    <= 2'h0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign rd_data  = state_q.rd_data;
    assign rd_valid = state_q.rd_valid;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence read_of(logic [ADDR_W-1:0] a);
        rd_en && (rd_addr == a);
    endsequence

    sequence answer_next;
        ##1 rd_valid;
    endsequence

    AST_PHASE_FIELD: assert property (read_of(STATUS_TWO_ADDR) |-> answer_next
        ##0 rd_data[7:6] == $past(live.charge_phase))
        else $error("charge phase field wrong");
    AST_SEQ_PG_BIT: assert property (read_of(STATUS_TWO_ADDR) |=>
        rd_data[5] == $past(live.sequence_power_good))
        else $error("sequence power good bit wrong");
    AST_IN_PG_BIT: assert property (read_of(STATUS_TWO_ADDR) |=>
        rd_data[1] == $past(live.input_power_good) && rd_data[4:2] == 3'h0)
        else $error("input power good bit or reserved bits wrong");
    AST_PIN_BITS: assert property (read_of(STATUS_THREE_ADDR) |=>
        rd_data[7:4] == $past(live.pin_level) && rd_data[3:2] == 2'h0)
        else $error("pin level bits wrong");
    AST_FLAG_CLEAR: assert property (read_of(EVENT_FLAGS_ADDR) ##0 (flag_set == 8'h00)
        |=> state_q.flags == 8'h00)
        else $error("flags not cleared by read");
    AST_OPEN_LATCH: assert property (primed && $rose(live.thermistor_open)
        |=> state_q.flags[7] ##1 (state_q.flags[7]
                                  || $past(rd_en && (rd_addr == EVENT_FLAGS_ADDR))))
        else $error("thermistor open flag not latched");
    AST_ZONE_LATCH: assert property (primed && $changed(live.thermistor_zone)
        |=> state_q.flags[6])
        else $error("zone change flag not latched");
    AST_ILIM_LATCH: assert property (primed && $rose(live.current_limit)
        |=> state_q.flags[2])
        else $error("current limit flag not latched");
    AST_PPATH_LATCH: assert property (primed && $rose(live.power_path_regulation)
        |=> state_q.flags[1])
        else $error("power path flag not latched");
    AST_VIN_LATCH: assert property (primed && $rose(live.input_voltage_regulation)
        |=> state_q.flags[0])
        else $error("input voltage flag not latched");
    AST_FLAG_RESERVED: assert property (read_of(EVENT_FLAGS_ADDR) |=>
        rd_data[5:3] == 3'h0)
        else $error("reserved flag bits not zero");
    AST_SET_WINS: assert property (read_of(EVENT_FLAGS_ADDR) ##0 (flag_set != 8'h00)
        |=> state_q.flags == $past(flag_set))
        else $error("coincident event lost");
    AST_READ_ANSWERED: assert property (rd_en |-> answer_next)
        else $error("read not answered in the next cycle");
    AST_NO_STRAY_ANSWER: assert property (!rd_en |=> !rd_valid)
        else $error("answer without a read");
    AST_OVP_BIT: assert property (read_of(STATUS_TWO_ADDR) |=>
        rd_data[0] == $past(live.input_overvoltage))
        else $error("input overvoltage bit wrong");
    AST_FAULT_BITS: assert property (read_of(STATUS_THREE_ADDR) |=>
        rd_data[1:0] == $past({live.battery_depletion_fault, live.thermal_shutdown}))
        else $error("depletion or thermal shutdown bit wrong");
    AST_UNMAPPED_ZERO: assert property (rd_en && (rd_addr > EVENT_FLAGS_ADDR)
        |=> rd_data == UNMAPPED_VALUE)
        else $error("unmapped address not zero");
    AST_FLAG_HOLD: assert property (!(rd_en && (rd_addr == EVENT_FLAGS_ADDR))
        && (flag_set == 8'h00) |=> $stable(state_q.flags))
        else $error("flags changed without event or read");

endmodule : charger_status_flag_regs

// *** verification/host_reader.sv ***
// Host side read master that turns bench requests into register reads
`timescale 1ns/100ps
module host_reader
    import charger_status_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              reset,
    input  wire logic              go,
    input  wire logic [ADDR_W-1:0] go_addr,
    output logic                   rd_en,
    output logic      [ADDR_W-1:0] rd_addr
);
    // Reads only: no write ever reaches the read-only registers
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            rd_en   <= 1'b0;
            rd_addr <= '0;
        end
        else
        begin
            rd_en   <= go;
            rd_addr <= go_addr;
        end
    end
endmodule : host_reader

// *** verification/test_charger_status_flag_regs.sv ***
// Self-checking bench for the charger status and event flag registers
`timescale 1ns/100ps
module test_charger_status_flag_regs
    import charger_status_pkg::*;
;
    localparam logic [7:0] EV_FLAG [4] = '{8'h80, 8'h04, 8'h02, 8'h01};
    logic        clk_sys = 1'b0;
    logic        reset   = 1'b1;
    logic        go      = 1'b0;
    logic [7:0]  addr    = 8'h00;
    logic        rd_en;
    logic [7:0]  rd_addr;
    logic [7:0]  rd_data;
    logic        rd_valid;
    logic [1:0]  phase   = 2'h0;
    logic        spg     = 1'b0;
    logic        ipg     = 1'b0;
    logic        ovp     = 1'b0;
    logic [3:0]  pins    = 4'h0;
    logic        dep     = 1'b0;
    logic        tsd     = 1'b0;
    logic [0:3]  ev      = 4'h0;
    logic [2:0]  zone    = 3'h0;
    logic [7:0]  notes [$];
    int          failures;
    int          comparisons;
    int          cycles;
    int          i;

    always #25 clk_sys = ~clk_sys;

    host_reader host (.clk_sys(clk_sys), .reset(reset), .go(go), .go_addr(addr),
                      .rd_en(rd_en), .rd_addr(rd_addr));

    charger_status_flag_regs uut (.clk_sys(clk_sys), .reset(reset), .rd_en(rd_en),
        .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid), .charge_phase(phase),
        .sequence_power_good(spg), .input_power_good(ipg), .input_overvoltage(ovp),
        .pin1_level(pins[3]), .pin2_level(pins[2]), .pin3_level(pins[1]),
        .pin4_level(pins[0]), .battery_depletion_fault(dep), .thermal_shutdown(tsd),
        .thermistor_open(ev[0]), .thermistor_zone(zone), .current_limit(ev[1]),
        .power_path_regulation(ev[2]), .input_voltage_regulation(ev[3]));

    task wrap_up;
        if (failures == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up

    task check(input logic [7:0] seen, input logic [7:0] want);
        comparisons++;
        if (seen !== want)
        begin
            failures++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check

    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        go   <= 1'b1;
        addr <= a;
        notes.push_back(e);
    endtask : rd

    task idle(input int n);
        @(posedge clk_sys);
        go <= 1'b0;
        repeat (n) @(posedge clk_sys);
    endtask : idle

    // Scoreboard: oldest note against each answered read
    always @(negedge clk_sys)
    begin
        if (rd_valid === 1'b1)
            check(rd_data, (notes.size() > 0) ? notes.pop_front() : 8'hxx);
    end

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            failures++;
            wrap_up();
        end
    end

    initial
    begin
        void'($urandom(32'h52bc7f46));
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        idle(6);
        rd(EVENT_FLAGS_ADDR, EVENT_FLAGS_RESET);
        rd(8'h05, UNMAPPED_VALUE);
        idle(2);
        for (i = 0; i < 12; i++)
        begin
            @(posedge clk_sys);
            phase <= i[1:0];
            {spg, ipg, ovp, pins, dep, tsd} <= 9'($urandom);
            idle(3);
            rd(STATUS_TWO_ADDR, {i[1:0], spg, 3'h0, ipg, ovp});
            rd(STATUS_THREE_ADDR, {pins, 2'h0, dep, tsd});
            idle(1);
        end
        for (i = 0; i < 4; i++)
        begin
            @(posedge clk_sys);
            ev[i] <= 1'b1;
            idle(9);
            rd(EVENT_FLAGS_ADDR, EV_FLAG[i]);
            rd(EVENT_FLAGS_ADDR, 8'h00);
            idle(0);
            ev[i] <= 1'b0;
            idle(6);
            rd(EVENT_FLAGS_ADDR, 8'h00);
            idle(1);
        end
        // Walk every zone code, returning to normal last
        for (i = 1; i <= 5; i++)
        begin
            @(posedge clk_sys);
            zone <= 3'(i % 5);
            idle(6);
            rd(EVENT_FLAGS_ADDR, 8'h40);
            rd(EVENT_FLAGS_ADDR, 8'h00);
            idle(1);
        end
        // Synced rise lands in the cycle of the clearing read
        @(posedge clk_sys);
        ev[3] <= 1'b1;
        rd(EVENT_FLAGS_ADDR, 8'h00);
        rd(EVENT_FLAGS_ADDR, 8'h01);
        rd(EVENT_FLAGS_ADDR, 8'h00);
        idle(1);
        ev[3] <= 1'b0;
        idle(4);
        @(posedge clk_sys);
        ev   <= 4'hf;
        zone <= ZONE_HOT;
        idle(6);
        rd(EVENT_FLAGS_ADDR, FLAG_DEFINED_MASK);
        idle(2);
        ev <= 4'h0;
        idle(6);
        @(posedge clk_sys);
        ev[2] <= 1'b1;
        idle(6);
        // Second reset with the flag set and the level dropped
        reset <= 1'b1;
        ev    <= 4'h0;
        idle(2);
        reset <= 1'b0;
        idle(6);
        rd(EVENT_FLAGS_ADDR, EVENT_FLAGS_RESET);
        idle(4);
        if (notes.size() != 0)
            failures++;
        wrap_up();
    end
endmodule : test_charger_status_flag_regs
